// File: rtl/pin_select.sv
// pin function select registers with axi4-lite slave and routing
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module pin_select (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        nmi_input_pin,
  input  wire logic [2:0]  cap3_pin,
  input  wire logic [2:0]  cap2_pin,
  input  wire logic [2:0]  cap1_pin,
  input  wire logic [2:0]  cap0_pin,
  input  wire logic [7:0]  serial_sync_signal,
  input  wire logic        oscillator_trim_signal,
  input  wire logic [2:0]  freerun_clock_pin,
  input  wire logic [2:0]  shutdown_pin,
  input  wire logic [1:0]  ignition_pin,
  input  wire logic        shutdown_flag,
  output logic             dbg_trst_tdi_en,
  output logic             dbg_tck_tms_tdo_en,
  output logic             usb1_pullup_out_en,
  output logic             usb0_pullup_out_en,
  output logic [2:0]       subclock_out_en,
  output logic [2:0]       rtc_clock_out_en,
  output logic [2:0]       osc_out_en,
  output logic             nmi_internal,
  output logic             nmi_request,
  output logic [3:0]       capture_in,
  output logic             freerun_clock_in,
  output logic             waveform_shutdown_input,
  output logic             ignition_trigger_in,
  output logic [7:0]       wave_out_en,
  output logic             wave_gpio_switch
);

  logic [31:0] sys_q;
  logic [31:0] tmr_q;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        nmi_s1_q;
  logic        nmi_s2_q;
  logic        nmi_prev_q;
  logic [3:0]  cap_s1_q;
  logic [3:0]  cap_s2_q;
  logic [2:0]  misc_s1_q;
  logic [2:0]  misc_s2_q;
  logic        shflag_s1_q;
  logic        shflag_s2_q;
  logic [3:0]  cap_d;
  logic        frck_d;
  logic        shdn_d;
  logic        ign_d;
  logic        nmi_d;
  logic        wr_go;

  // 3-way pin position decode of a 2-bit output select, 00 off
  function automatic logic [2:0] out3(input logic [1:0] code);
    logic [2:0] r;
    r = 3'h0;
    if (code != 2'h0) begin
      r[code - 2'h1] = 1'b1;
    end
    return r;
  endfunction

  // 2-bit input select, 00/01 pin 0, 10 pin 1, 11 pin 2
  function automatic logic pick3(input logic [1:0] code,
                                 input logic [2:0] pins);
    logic r;
    r = pins[0];
    case (code)
      2'h2:    r = pins[1];
      2'h3:    r = pins[2];
      default: r = pins[0];
    endcase
    return r;
  endfunction

  // merge write data into a register under byte strobes and writable mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // write address and data captured independently, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // register update; only the ordinary reset clears them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_q <= pin_select_pkg::SYS_SEL_RESET;
      tmr_q <= pin_select_pkg::TMR_SEL_RESET;
    end else if (wr_go) begin
      if (awaddr_q[11:2] == pin_select_pkg::SYS_SEL_OFFSET[11:2]) begin
        sys_q <= merge(sys_q, wdata_q, wstrb_q,
                       pin_select_pkg::SYS_SEL_MASK);
      end
      if (awaddr_q[11:2] == pin_select_pkg::TMR_SEL_OFFSET[11:2]) begin
        tmr_q <= merge(tmr_q, wdata_q, wstrb_q,
                       pin_select_pkg::TMR_SEL_MASK);
      end
    end
  end

  // write response, slverr on unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pin_select_pkg::AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q[11:2] == pin_select_pkg::SYS_SEL_OFFSET[11:2] ||
          awaddr_q[11:2] == pin_select_pkg::TMR_SEL_OFFSET[11:2]) begin
        s_axi_bresp <= pin_select_pkg::AXI_OKAY;
      end else begin
        s_axi_bresp <= pin_select_pkg::AXI_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= pin_select_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pin_select_pkg::AXI_OKAY;
        if (s_axi_araddr[11:2] == pin_select_pkg::SYS_SEL_OFFSET[11:2]) begin
          s_axi_rdata <= sys_q;
        end else if (s_axi_araddr[11:2] ==
                     pin_select_pkg::TMR_SEL_OFFSET[11:2]) begin
          s_axi_rdata <= tmr_q;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= pin_select_pkg::AXI_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // two-flop synchronisers for pin and peripheral inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_s1_q    <= 1'b1;
      nmi_s2_q    <= 1'b1;
      cap_s1_q    <= 4'h0;
      cap_s2_q    <= 4'h0;
      misc_s1_q   <= 3'h0;
      misc_s2_q   <= 3'h0;
      shflag_s1_q <= 1'b0;
      shflag_s2_q <= 1'b0;
    end else begin
      nmi_s1_q    <= nmi_input_pin;
      nmi_s2_q    <= nmi_s1_q;
      cap_s1_q    <= cap_d;
      cap_s2_q    <= cap_s1_q;
      misc_s1_q   <= {frck_d, shdn_d, ign_d};
      misc_s2_q   <= misc_s1_q;
      shflag_s1_q <= shutdown_flag;
      shflag_s2_q <= shflag_s1_q;
    end
  end

  // input capture and timer input source selection (mux before sync)
  always_comb begin
    cap_d = 4'h0;
    for (int n = 0; n < 4; n++) begin
      logic [2:0] code;
      logic [2:0] pins;
      code = tmr_q[pin_select_pkg::CAP0_LSB + 3*n +: 3];
      pins = (n == 0) ? cap0_pin : (n == 1) ? cap1_pin :
             (n == 2) ? cap2_pin : cap3_pin;
      case (code)
        3'h0, 3'h1: cap_d[n] = pins[0];
        3'h2:       cap_d[n] = pins[1];
        3'h3:       cap_d[n] = pins[2];
        3'h4:       cap_d[n] = serial_sync_signal[n];
        3'h5:       cap_d[n] = serial_sync_signal[n + 4];
        3'h7:       cap_d[n] = (n == 3) ? oscillator_trim_signal : 1'b0;
        default:    cap_d[n] = 1'b0;
      endcase
    end
    frck_d = pick3(tmr_q[pin_select_pkg::FRCK_LSB +: 2],
                   freerun_clock_pin);
    shdn_d = pick3(tmr_q[pin_select_pkg::SHDN_LSB +: 2],
                   shutdown_pin);
    ign_d  = tmr_q[pin_select_pkg::IGN_BIT] ? ignition_pin[1]
                                            : ignition_pin[0];
    nmi_d  = sys_q[pin_select_pkg::NMI_BIT] ? nmi_s2_q : 1'b1;
  end

  // registered routing outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_trst_tdi_en         <= 1'b1;
      dbg_tck_tms_tdo_en      <= 1'b1;
      usb1_pullup_out_en      <= 1'b0;
      usb0_pullup_out_en      <= 1'b0;
      subclock_out_en         <= 3'h0;
      rtc_clock_out_en        <= 3'h0;
      osc_out_en              <= 3'h0;
      capture_in              <= 4'h0;
      freerun_clock_in        <= 1'b0;
      waveform_shutdown_input <= 1'b1;
      ignition_trigger_in     <= 1'b0;
      wave_out_en             <= 8'h00;
      wave_gpio_switch        <= 1'b0;
    end else begin
      dbg_trst_tdi_en    <= sys_q[pin_select_pkg::DBG1_BIT];
      dbg_tck_tms_tdo_en <= sys_q[pin_select_pkg::DBG0_BIT];
      usb1_pullup_out_en <= sys_q[pin_select_pkg::USB1_BIT];
      usb0_pullup_out_en <= sys_q[pin_select_pkg::USB0_BIT];
      subclock_out_en  <= out3(sys_q[pin_select_pkg::SUBOUT_LSB +: 2]);
      rtc_clock_out_en <= out3(sys_q[pin_select_pkg::RTCOUT_LSB +: 2]);
      osc_out_en       <= out3(sys_q[pin_select_pkg::OSCOUT_LSB +: 2]);
      capture_in              <= cap_s2_q;
      freerun_clock_in        <= misc_s2_q[2];
      waveform_shutdown_input <= misc_s2_q[1];
      ignition_trigger_in     <= misc_s2_q[0];
      for (int w = 0; w < 4; w++) begin
        // bit pair per wave: [0] pin 0, [1] pin 1; 11 barred
        case (tmr_q[pin_select_pkg::WAVE2_LSB + 2*w +: 2])
          2'h1:    wave_out_en[2*w +: 2] <= 2'h1;
          2'h2:    wave_out_en[2*w +: 2] <= 2'h2;
          default: wave_out_en[2*w +: 2] <= 2'h0;
        endcase
      end
      wave_gpio_switch <= tmr_q[pin_select_pkg::SHGPIO_BIT] &&
                          shflag_s2_q;
    end
  end

  // internal nmi level and falling-edge request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_prev_q   <= 1'b1;
      nmi_internal <= 1'b1;
      nmi_request  <= 1'b0;
    end else begin
      nmi_prev_q   <= nmi_d;
      nmi_internal <= nmi_d;
      nmi_request  <= nmi_prev_q && !nmi_d;
    end
  end

endmodule

// File: rtl/pin_select_pkg.sv
// constants for the system and timer unit 0 pin function select block
// Summary of operation
// - debug select 1 high (reset) gives test reset and data-in pins to debug
// - bit 16 high (reset) gives test clock, mode and data-out pins to debug
// - reserved bits read zero; software writes zero to them
// - bit 13 high drives usb1 pull-up control onto its pin
// - bit 9 high drives usb0 pull-up control onto its pin
// - sub clock output field 00 off, 01..11 pin positions 0..2
// - rtc clock output field 00 off, 01..11 pin positions 0..2
// - oscillator output field 00 off, 01..11 pin positions 0..2
// - bit 0 high uses the nmi input pin
// - registers survive deep standby reset; only ordinary reset clears them
// - internal nmi held high while pin not assigned to nmi
// - switching to nmi with pin low gives falling edge and nmi request
// - capture 3 source: pins 0..2, serial 3/7 sync, 110 barred, 111 trim
// - capture 2..0 source: pins 0..2, serial n / n+4 sync, 11x barred
// - free-run clock source: 00/01 pin 0, 10 pin 1, 11 pin 2
// - shutdown input source: 00/01 pin 0, 10 pin 1, 11 pin 2
// - ignition trigger: 0 pin position 0, 1 pin position 1
// - bit 12 high lets shutdown flag switch waves 00..05 to gpio
// - wave 05..03 enable: 00 off, 01 pin 0, 10 pin 1, 11 barred
// - wave 02 enable decodes the same way
package pin_select_pkg;
  localparam logic [11:0] SYS_SEL_OFFSET   = 12'h000;
  localparam logic [11:0] TMR_SEL_OFFSET   = 12'h004;
  localparam logic [31:0] SYS_SEL_RESET    = 32'h00030000;
  localparam logic [31:0] TMR_SEL_RESET    = 32'h00000000;
  // writable bits; all others reserved and read zero
  localparam logic [31:0] SYS_SEL_MASK     = 32'h000322F7;
  localparam logic [31:0] TMR_SEL_MASK     = 32'hFFFF3FF0;
  localparam int DBG1_BIT    = 17;
  localparam int DBG0_BIT    = 16;
  localparam int USB1_BIT    = 13;
  localparam int USB0_BIT    = 9;
  localparam int SUBOUT_LSB  = 6;
  localparam int RTCOUT_LSB  = 4;
  localparam int OSCOUT_LSB  = 1;
  localparam int NMI_BIT     = 0;
  localparam int CAP3_LSB    = 29;
  localparam int CAP2_LSB    = 26;
  localparam int CAP1_LSB    = 23;
  localparam int CAP0_LSB    = 20;
  localparam int FRCK_LSB    = 18;
  localparam int SHDN_LSB    = 16;
  localparam int IGN_BIT     = 13;
  localparam int SHGPIO_BIT  = 12;
  localparam int WAVE5_LSB   = 10;
  localparam int WAVE2_LSB   = 4;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// File: verification/pin_partner.sv
// far side model: package pins and peripheral sync signals
`timescale 1ns/1ps
module pin_partner (
  input  wire logic [29:0] pat,
  input  wire logic        nmi_low,
  output logic             nmi_input_pin,
  output logic [11:0]      cap_pins,
  output logic [7:0]       serial_sync_signal,
  output logic             oscillator_trim_signal,
  output logic [2:0]       freerun_clock_pin,
  output logic [2:0]       shutdown_pin,
  output logic [1:0]       ignition_pin,
  output logic             shutdown_flag
);
  // nmi pin idles high so a change of assignment raises nothing
  assign nmi_input_pin = !nmi_low;
  // every other line follows the pattern the bench holds
  assign {shutdown_flag, ignition_pin, shutdown_pin, freerun_clock_pin,
          oscillator_trim_signal, serial_sync_signal, cap_pins} = pat;
endmodule

// File: verification/pin_select_properties.sv
// checker on the pin function select block ports
`timescale 1ns/1ps
module pin_select_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        dbg_trst_tdi_en,
  input wire logic        dbg_tck_tms_tdo_en,
  input wire logic [2:0]  subclock_out_en,
  input wire logic [2:0]  rtc_clock_out_en,
  input wire logic [2:0]  osc_out_en,
  input wire logic        nmi_internal,
  input wire logic        nmi_request,
  input wire logic [7:0]  wave_out_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [11:0] ar_q;
  logic [31:0] keep;
  // address of the read under way picks which bits may read nonzero
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  assign keep = (ar_q == pin_select_pkg::TMR_SEL_OFFSET) ?
    pin_select_pkg::TMR_SEL_MASK : pin_select_pkg::SYS_SEL_MASK;
  property p_rst; disable iff (1'b0) !aresetn [*2] |=> dbg_trst_tdi_en &&
    dbg_tck_tms_tdo_en && nmi_internal && !s_axi_bvalid; endproperty
  a_rst: assert property (p_rst)
    else $error("reset outputs wrong");
  property p_nmi_pulse; nmi_request |=> !nmi_request; endproperty
  a_nmi_pulse: assert property (p_nmi_pulse)
    else $error("nmi request longer than one cycle");
  property p_nmi_low; nmi_request |-> !nmi_internal; endproperty
  a_nmi_low: assert property (p_nmi_low)
    else $error("nmi request with internal nmi high");
  property p_wave; (wave_out_en & {wave_out_en[6:0], 1'b0} & 8'hAA) == 8'h00;
  endproperty
  a_wave: assert property (p_wave)
    else $error("wave output on two pins");
  property p_sub; $onehot0(subclock_out_en); endproperty
  a_sub: assert property (p_sub)
    else $error("sub clock output on two pins");
  property p_rtc; $onehot0(rtc_clock_out_en); endproperty
  a_rtc: assert property (p_rtc)
    else $error("rtc clock output on two pins");
  property p_osc; $onehot0(osc_out_en); endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator output on two pins");
  property p_bstand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bstand: assert property (p_bstand)
    else $error("write response dropped");
  property p_rstand; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rstand: assert property (p_rstand)
    else $error("read data dropped or changed");
  property p_rsvd; s_axi_rvalid |-> (s_axi_rdata & ~keep) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");
  c_nmi: cover property (nmi_request);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_wave: cover property (wave_out_en != 8'h00);
endmodule
bind pin_select pin_select_properties chk (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .dbg_trst_tdi_en, .dbg_tck_tms_tdo_en,
  .subclock_out_en, .rtc_clock_out_en, .osc_out_en, .nmi_internal,
  .nmi_request, .wave_out_en);

// File: verification/pin_select_tb.sv
// self-checking bench for the pin function select block
`timescale 1ns/1ps
module pin_select_tb;
  localparam logic [11:0] SYS = pin_select_pkg::SYS_SEL_OFFSET;
  localparam logic [11:0] TMR = pin_select_pkg::TMR_SEL_OFFSET;
  localparam logic [1:0]  OK  = pin_select_pkg::AXI_OKAY;
  localparam logic [1:0]  ERR = pin_select_pkg::AXI_SLVERR;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, nmi_input_pin;
  logic        oscillator_trim_signal, shutdown_flag, dbg_trst_tdi_en;
  logic        dbg_tck_tms_tdo_en, usb1_pullup_out_en, usb0_pullup_out_en;
  logic        nmi_internal, nmi_request, freerun_clock_in, nmi_low;
  logic        waveform_shutdown_input, ignition_trigger_in, wave_gpio_switch;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, capture_in;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ignition_pin;
  logic [2:0]  cap3_pin, cap2_pin, cap1_pin, cap0_pin, freerun_clock_pin;
  logic [2:0]  shutdown_pin, subclock_out_en, rtc_clock_out_en, osc_out_en;
  logic [7:0]  serial_sync_signal, wave_out_en;
  logic [29:0] pat;
  logic [33:0] expq[$];
  int          fails, n_tests, nmi_seen;
  pin_select DUT (.*);
  pin_partner far (.pat, .nmi_low, .nmi_input_pin, .serial_sync_signal,
    .cap_pins({cap3_pin, cap2_pin, cap1_pin, cap0_pin}), .shutdown_flag,
    .oscillator_trim_signal, .freerun_clock_pin, .shutdown_pin, .ignition_pin);
  // clock at 200 MHz
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    fails++;
    print_verdict();
  endtask
  task automatic check(input string nm, input logic [33:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one write; the response code is noted for the monitor
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] rsp);
    expq.push_back({rsp, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50 && !s_axi_bvalid; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) hang();
    @(posedge aclk);
  endtask
  // one read; the expected response and data are noted
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    expq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50 && !s_axi_rvalid; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) hang();
    @(posedge aclk);
  endtask
  // capture n input for source code c with pin pattern p
  function automatic logic capx(input int n, input logic [2:0] c,
                                input logic [29:0] p);
    case (c)
      3'h0, 3'h1: return p[3*n];
      3'h2: return p[3*n+1];
      3'h3: return p[3*n+2];
      3'h4: return p[12+n];
      3'h5: return p[16+n];
      3'h7: return (n == 3) ? p[20] : 1'b0;
      default: return 1'b0;
    endcase
  endfunction
  // monitor: oldest note against each response handed over
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", {s_axi_bresp, 32'h0}, expq.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      check("rdata", {s_axi_rresp, s_axi_rdata}, expq.pop_front());
    if (nmi_request) nmi_seen++;
  end
  initial begin
    logic [31:0] v;
    logic [29:0] p;
    logic [2:0]  e;
    logic [1:0]  ep;
    logic [3:0]  ce;
    int          j;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, nmi_low, pat} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {fails, n_tests, nmi_seen} = '0;
    void'($urandom(32'hDDDE));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(SYS, {OK, 32'h00030000});
    rd(TMR, {OK, 32'h00000000});
    check("dbg", {dbg_trst_tdi_en, dbg_tck_tms_tdo_en}, 2'h3);
    $display("reset test done");
    // every clock output code with random other bits, nmi left off
    for (int c = 0; c < 4; c++) begin
      v = $urandom();
      v[0] = 1'b0;
      {v[7:6], v[5:4], v[2:1]} = {3{c[1:0]}};
      wr(SYS, v, OK);
      rd(SYS, {OK, v & pin_select_pkg::SYS_SEL_MASK});
      repeat (4) @(posedge aclk);
      e = (c == 0) ? 3'h0 : 3'h1 << (c - 1);
      check("clkout", {subclock_out_en, rtc_clock_out_en, osc_out_en},
            {e, e, e});
      check("pins", {dbg_trst_tdi_en, dbg_tck_tms_tdo_en, usb1_pullup_out_en,
            usb0_pullup_out_en, nmi_internal},
            {v[17], v[16], v[13], v[9], 1'b1});
    end
    $display("system select test done");
    // every source code on all timer inputs with a random pin pattern
    for (int c = 0; c < 8; c++) begin
      p = $urandom();
      pat <= p;
      v = {{4{c[2:0]}}, {2{c[1:0]}}, 2'h0, {2{c[0]}}, {4{c[1:0]}}, 4'h0};
      wr(TMR, v, OK);
      rd(TMR, {OK, v});
      repeat (4) @(posedge aclk);
      for (int n = 0; n < 4; n++) ce[n] = capx(n, c[2:0], p);
      j = (c[1:0] < 2) ? 0 : c[1:0] - 1;
      ep = (c[1:0] == 2'h1) ? 2'h1 : (c[1:0] == 2'h2) ? 2'h2 : 2'h0;
      check("capture", capture_in, ce);
      check("route", {freerun_clock_in, waveform_shutdown_input,
            ignition_trigger_in, wave_gpio_switch},
            {p[21+j], p[24+j], p[27+c[0]], c[0] & p[29]});
      check("wave", wave_out_en, {4{ep}});
    end
    $display("timer select test done");
    wr(12'h008, 32'hFFFFFFFF, ERR);
    rd(12'h008, {ERR, 32'h0});
    $display("unmapped test done");
    // pin low while not selected, then selected against a low pin
    nmi_low <= 1'b1;
    wr(SYS, 32'h00030000, OK);
    repeat (4) @(posedge aclk);
    check("nmi_int", nmi_internal, 1'b1);
    wr(SYS, 32'h00030001, OK);
    repeat (6) @(posedge aclk);
    check("nmi_req", {nmi_internal, nmi_seen}, {1'b0, 32'd1});
    nmi_low <= 1'b0;
    wr(SYS, 32'h000020C2, OK);
    $display("nmi test done");
    // a second ordinary reset restores the initial contents
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(SYS, {OK, 32'h00030000});
    $display("second reset test done");
    print_verdict();
  end
endmodule
